//--- hw/mbj_mailbox_ctrl.v
// bin routing, full reporting, jam detection and automatic clearing for a three-bin mailbox
// What this block does
// - stacker routes lowest bin first, then upward
// - lowest full moves to middle, middle to top
// - stacker reports mailbox full on top full
// - staple request with lowest full reports full
// - mailbox mode routes job to designated bin
// - mailbox mode reports full on designated full
// - feed delay jam a after fuser edge timeout
// - feed delay jam b after fuser edge timeout
// - stationary jam a when trailing edge late
// - stationary jam b when trailing edge late
// - stationary jam three after staple feed timeout
// - residual jam when paper persists during clearing
// - initial sequence clears residual paper automatically
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "mbj_consts.vh"
module mbj_mailbox_ctrl (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // bin full sensor pins
  input  wire        full_low_pin,
  input  wire        full_mid_pin,
  input  wire        full_top_pin,
  // paper path sensor pins
  input  wire        fuser_delivery_pin,
  input  wire        path_feed_sensor_a,
  input  wire        path_feed_sensor_b,
  input  wire        lowest_bin_delivery_sensor,
  input  wire        door_closed_pin,
  // staple sequencer, same clock
  input  wire        staple_feed_start,
  // reports and drives
  output reg  [1:0]  route_bin,
  output reg         full_report,
  output wire        jam_report,
  output reg         clear_drive
);
  // one-hot clearing states
  localparam [2:0] CS_IDLE  = 3'b001;
  localparam [2:0] CS_CHECK = 3'b010;
  localparam [2:0] CS_CLEAR = 3'b100;

  // synchronised levels
  wire [`MBJ_NSYNC-1:0] lvl;
  wire full_low = lvl[0];
  wire full_mid = lvl[1];
  wire full_top = lvl[2];
  wire fuser    = lvl[3];
  wire sens_a   = lvl[4];
  wire sens_b   = lvl[5];
  wire deliv    = lvl[6];
  wire door     = lvl[7];

  mbj_sync u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  ({door_closed_pin, lowest_bin_delivery_sensor, path_feed_sensor_b,
               path_feed_sensor_a, fuser_delivery_pin, full_top_pin, full_mid_pin,
               full_low_pin}),
    .lvl_out (lvl)
  );

  // registers
  reg [4:0]         ctrl_reg;
  reg [`MBJ_TW-1:0] t_feed_reg;
  reg [`MBJ_TW-1:0] t_stat_reg;
  reg [`MBJ_TW-1:0] t_stat3_reg;
  reg [`MBJ_TW-1:0] t_resid_reg;
  reg [5:0]         jam_reg;
  reg [2:0]         cs_reg;
  reg [2:0]         cs_next;
  reg [7:0]         prev_reg;
  reg               clr_req_reg;

  // timer state
  reg               dly_a_run_reg;
  reg               dly_b_run_reg;
  reg               st_a_run_reg;
  reg               st_b_run_reg;
  reg               st3_run_reg;
  reg [`MBJ_TW-1:0] dly_a_cnt_reg;
  reg [`MBJ_TW-1:0] dly_b_cnt_reg;
  reg [`MBJ_TW-1:0] st_a_cnt_reg;
  reg [`MBJ_TW-1:0] st_b_cnt_reg;
  reg [`MBJ_TW-1:0] st3_cnt_reg;
  reg [`MBJ_TW-1:0] res_cnt_reg;

  // saturating count step
  function [`MBJ_TW-1:0] tick;
    input               run;
    input [`MBJ_TW-1:0] cnt;
    begin
      if (!run) begin
        tick = {`MBJ_TW{1'b0}};
      end else if (&cnt) begin
        tick = cnt;
      end else begin
        tick = cnt + 1'b1;
      end
    end
  endfunction

  // byte-lane merge of a write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (st[k]) begin
          merge[k*8 +: 8] = wd[k*8 +: 8];
        end
      end
    end
  endfunction

  // edge detection on filtered levels
  wire fuser_rise = fuser & ~prev_reg[3];
  wire a_rise     = sens_a & ~prev_reg[4];
  wire a_fall     = ~sens_a & prev_reg[4];
  wire b_rise     = sens_b & ~prev_reg[5];
  wire b_fall     = ~sens_b & prev_reg[5];
  wire d_fall     = ~deliv & prev_reg[6];
  wire door_rise  = door & ~prev_reg[7];
  wire any_paper  = sens_a | sens_b | deliv;

  // timeout hits
  wire hit_dly_a = dly_a_run_reg & (dly_a_cnt_reg >= t_feed_reg);
  wire hit_dly_b = dly_b_run_reg & (dly_b_cnt_reg >= t_feed_reg);
  wire hit_st_a  = st_a_run_reg & (st_a_cnt_reg >= t_stat_reg);
  wire hit_st_b  = st_b_run_reg & (st_b_cnt_reg >= t_stat_reg);
  wire hit_st3   = st3_run_reg & (st3_cnt_reg >= t_stat3_reg);
  wire clearing  = cs_reg[2];
  wire hit_res   = clearing & any_paper & (res_cnt_reg >= t_resid_reg);
  wire pass_ok   = clearing & ~any_paper;

  // bin routing and full report
  wire       mbx_mode = ctrl_reg[`MBJ_CTRL_MODE];
  wire [1:0] des_bin  = ctrl_reg[`MBJ_CTRL_BIN_HI:`MBJ_CTRL_BIN_LO];
  reg  [1:0] route_next;
  reg        full_next;
  reg        des_full;
  always @* begin
    case (des_bin)
      `MBJ_BIN_LOW: des_full = full_low;
      `MBJ_BIN_MID: des_full = full_mid;
      default:      des_full = full_top;
    endcase
    if (mbx_mode) begin
      route_next = des_bin[1] ? `MBJ_BIN_TOP : des_bin;  // code 3 acts as top
      full_next  = des_full;
    end else begin
      if (!full_low) begin
        route_next = `MBJ_BIN_LOW;
      end else if (!full_mid) begin
        route_next = `MBJ_BIN_MID;
      end else begin
        route_next = `MBJ_BIN_TOP;
      end
      full_next = full_top;
    end
    if (ctrl_reg[`MBJ_CTRL_STAPLE] && full_low) begin
      full_next = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_bin   <= `MBJ_BIN_LOW;
      full_report <= 1'b0;
    end else begin
      route_bin   <= route_next;
      full_report <= full_next;
    end
  end

  // clearing sequence state machine
  always @* begin
    cs_next = cs_reg;
    case (cs_reg)
      CS_IDLE: begin
        if (door_rise || clr_req_reg) begin
          cs_next = CS_CHECK;
        end
      end
      CS_CHECK: begin
        if (!door) begin
          cs_next = CS_IDLE;
        end else if (any_paper) begin
          cs_next = CS_CLEAR;
        end else begin
          cs_next = CS_IDLE;
        end
      end
      CS_CLEAR: begin
        if (!door || pass_ok || hit_res) begin
          cs_next = CS_IDLE;
        end
      end
      default: cs_next = CS_IDLE;
    endcase
  end

  // state, motor drive and residual counter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_reg      <= CS_CHECK;                           // power-on runs the check
      clear_drive <= 1'b0;
      res_cnt_reg <= {`MBJ_TW{1'b0}};
      prev_reg    <= 8'h00;
    end else begin
      cs_reg      <= cs_next;
      clear_drive <= (cs_next == CS_CLEAR);
      res_cnt_reg <= tick(clearing & any_paper, res_cnt_reg);
      prev_reg    <= lvl;
    end
  end

  // jam timers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_a_run_reg <= 1'b0;
      dly_b_run_reg <= 1'b0;
      st_a_run_reg  <= 1'b0;
      st_b_run_reg  <= 1'b0;
      st3_run_reg   <= 1'b0;
      dly_a_cnt_reg <= {`MBJ_TW{1'b0}};
      dly_b_cnt_reg <= {`MBJ_TW{1'b0}};
      st_a_cnt_reg  <= {`MBJ_TW{1'b0}};
      st_b_cnt_reg  <= {`MBJ_TW{1'b0}};
      st3_cnt_reg   <= {`MBJ_TW{1'b0}};
    end else begin
      dly_a_run_reg <= fuser_rise | (dly_a_run_reg & ~a_rise & ~hit_dly_a);
      dly_b_run_reg <= fuser_rise | (dly_b_run_reg & ~b_rise & ~hit_dly_b);
      st_a_run_reg  <= a_rise | (st_a_run_reg & ~a_fall & ~hit_st_a);
      st_b_run_reg  <= b_rise | (st_b_run_reg & ~b_fall & ~hit_st_b);
      st3_run_reg   <= staple_feed_start | (st3_run_reg & ~d_fall & ~hit_st3);
      dly_a_cnt_reg <= fuser_rise ? {`MBJ_TW{1'b0}} : tick(dly_a_run_reg, dly_a_cnt_reg);
      dly_b_cnt_reg <= fuser_rise ? {`MBJ_TW{1'b0}} : tick(dly_b_run_reg, dly_b_cnt_reg);
      st_a_cnt_reg  <= a_rise ? {`MBJ_TW{1'b0}} : tick(st_a_run_reg, st_a_cnt_reg);
      st_b_cnt_reg  <= b_rise ? {`MBJ_TW{1'b0}} : tick(st_b_run_reg, st_b_cnt_reg);
      st3_cnt_reg   <= staple_feed_start ? {`MBJ_TW{1'b0}} : tick(st3_run_reg, st3_cnt_reg);
    end
  end

  // sticky jam flags, a new jam wins over a clearing pass
  wire [5:0] jam_set = {hit_res, hit_st3, hit_st_b, hit_st_a, hit_dly_b, hit_dly_a};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jam_reg <= 6'h00;
    end else begin
      jam_reg <= (jam_reg & {6{~pass_ok}}) | jam_set;
    end
  end

  assign jam_report = |jam_reg;

  // axi4-lite write path
  reg        aw_full_reg;
  reg        w_full_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;
  wire do_write = aw_full_reg & w_full_reg;
  wire wr_hit   = (aw_addr_reg == `MBJ_OFS_CTRL) || (aw_addr_reg == `MBJ_OFS_STATUS) ||
                  (aw_addr_reg == `MBJ_OFS_T_FEED) || (aw_addr_reg == `MBJ_OFS_T_STAT) ||
                  (aw_addr_reg == `MBJ_OFS_T_STAT3) || (aw_addr_reg == `MBJ_OFS_T_RESID);
  wire [31:0] ctrl_wr  = merge({27'h000_0000, ctrl_reg}, w_data_reg, w_strb_reg);
  wire [31:0] tfeed_wr = merge({8'h00, t_feed_reg}, w_data_reg, w_strb_reg);
  wire [31:0] tstat_wr = merge({8'h00, t_stat_reg}, w_data_reg, w_strb_reg);
  wire [31:0] tst3_wr  = merge({8'h00, t_stat3_reg}, w_data_reg, w_strb_reg);
  wire [31:0] tres_wr  = merge({8'h00, t_resid_reg}, w_data_reg, w_strb_reg);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MBJ_RESP_OKAY;
      ctrl_reg     <= `MBJ_CTRL_RST;
      clr_req_reg  <= 1'b0;
      t_feed_reg   <= `MBJ_T_FEED_RST;
      t_stat_reg   <= `MBJ_T_STAT_RST;
      t_stat3_reg  <= `MBJ_T_STAT3_RST;
      t_resid_reg  <= `MBJ_T_RESID_RST;
    end else begin
      clr_req_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `MBJ_RESP_OKAY : `MBJ_RESP_SLVERR;
        case (aw_addr_reg)
          `MBJ_OFS_CTRL: begin
            ctrl_reg    <= {1'b0, ctrl_wr[3:0]};         // clear bit is self-clearing
            clr_req_reg <= ctrl_wr[`MBJ_CTRL_CLEAR];
          end
          `MBJ_OFS_T_FEED:  t_feed_reg  <= tfeed_wr[`MBJ_TW-1:0];   // upper byte dropped
          `MBJ_OFS_T_STAT:  t_stat_reg  <= tstat_wr[`MBJ_TW-1:0];
          `MBJ_OFS_T_STAT3: t_stat3_reg <= tst3_wr[`MBJ_TW-1:0];
          `MBJ_OFS_T_RESID: t_resid_reg <= tres_wr[`MBJ_TW-1:0];
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read path
  assign s_axi_arready = ~s_axi_rvalid;
  reg [31:0] rd_mux;
  reg        rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `MBJ_OFS_CTRL:    rd_mux = {27'h000_0000, ctrl_reg};
      `MBJ_OFS_STATUS:  rd_mux = {17'h0_0000, deliv, sens_b, sens_a, 1'b0, clearing,
                                  jam_reg, 1'b0, full_report, route_bin};
      `MBJ_OFS_T_FEED:  rd_mux = {8'h00, t_feed_reg};
      `MBJ_OFS_T_STAT:  rd_mux = {8'h00, t_stat_reg};
      `MBJ_OFS_T_STAT3: rd_mux = {8'h00, t_stat3_reg};
      `MBJ_OFS_T_RESID: rd_mux = {8'h00, t_resid_reg};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MBJ_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `MBJ_RESP_OKAY : `MBJ_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- inc/mbj_consts.vh
// register offsets, field positions, reset values and timeout defaults for the mailbox controller
`ifndef MBJ_CONSTS_VH
`define MBJ_CONSTS_VH

// register byte offsets
`define MBJ_OFS_CTRL        8'h00
`define MBJ_OFS_STATUS      8'h04
`define MBJ_OFS_T_FEED      8'h08
`define MBJ_OFS_T_STAT      8'h0c
`define MBJ_OFS_T_STAT3     8'h10
`define MBJ_OFS_T_RESID     8'h14

// control register fields
`define MBJ_CTRL_MODE       0
`define MBJ_CTRL_BIN_LO     1
`define MBJ_CTRL_BIN_HI     2
`define MBJ_CTRL_STAPLE     3
`define MBJ_CTRL_CLEAR      4
`define MBJ_CTRL_RST        5'h00

// status register fields
`define MBJ_ST_BIN_LO       0
`define MBJ_ST_FULL         2
`define MBJ_ST_JAM_LO       4
`define MBJ_ST_CLEARING     10
`define MBJ_ST_SENS_LO      12

// jam flag positions inside the jam vector
`define MBJ_JAM_DLY_A       0
`define MBJ_JAM_DLY_B       1
`define MBJ_JAM_STAT_A      2
`define MBJ_JAM_STAT_B      3
`define MBJ_JAM_STAT3       4
`define MBJ_JAM_RESID       5

// bin codes
`define MBJ_BIN_LOW         2'h0
`define MBJ_BIN_MID         2'h1
`define MBJ_BIN_TOP         2'h2

// timeout defaults in clock cycles
`define MBJ_TW              24
`define MBJ_T_FEED_RST      24'h0f_4240
`define MBJ_T_STAT_RST      24'h1e_8480
`define MBJ_T_STAT3_RST     24'h2d_c6c0
`define MBJ_T_RESID_RST     24'h3d_0900

// pin synchroniser width
`define MBJ_NSYNC           8

// axi response codes
`define MBJ_RESP_OKAY       2'h0
`define MBJ_RESP_SLVERR     2'h2

`endif

//--- hw/mbj_sync.v
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
`include "mbj_consts.vh"
module mbj_sync (
  // clock and reset
  input  wire                      clk,
  input  wire                      rst_n,
  // raw pins and filtered levels
  input  wire [`MBJ_NSYNC-1:0]     pin_in,
  output reg  [`MBJ_NSYNC-1:0]     lvl_out
);
  reg [`MBJ_NSYNC-1:0] s1_reg;
  reg [`MBJ_NSYNC-1:0] s2_reg;
  reg [`MBJ_NSYNC-1:0] s3_reg;
  integer i;

  // shift chain and agreement filter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg  <= {`MBJ_NSYNC{1'b0}};
      s2_reg  <= {`MBJ_NSYNC{1'b0}};
      s3_reg  <= {`MBJ_NSYNC{1'b0}};
      lvl_out <= {`MBJ_NSYNC{1'b0}};
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < `MBJ_NSYNC; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          lvl_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/mbj_ctrl_sva.sv
// checker for bus handshakes, full reports, jam flags and clearing
`timescale 1ns/100ps
`default_nettype none
module mbj_ctrl_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // sensors and reports
  input wire logic        full_low_pin,
  input wire logic        full_mid_pin,
  input wire logic        full_top_pin,
  input wire logic        door_closed_pin,
  input wire logic        full_report,
  input wire logic        jam_report,
  input wire logic        clear_drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // address and data taken together
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // no bin reports full at its sensor
  sequence no_full;
    !full_low_pin && !full_mid_pin && !full_top_pin;
  endsequence
  wr_answer_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  no_full_a: assert property (no_full [*8] |=> !full_report)
    else $error("full reported with no bin full");
  jam_sticky_a: assert property ($fell(jam_report) |->
    $past(clear_drive) || $past(clear_drive, 2)) else $error("jam dropped without clearing");
  door_abort_a: assert property (!door_closed_pin [*8] |=> !clear_drive)
    else $error("clearing runs with door open");
endmodule
bind mbj_mailbox_ctrl mbj_ctrl_chk chk (
  .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .full_low_pin(full_low_pin), .full_mid_pin(full_mid_pin),
  .full_top_pin(full_top_pin), .door_closed_pin(door_closed_pin),
  .full_report(full_report), .jam_report(jam_report), .clear_drive(clear_drive));
`default_nettype wire

//--- testbench/mbj_paper_model.sv
// paper path model: fuser and path sensors seen by the mailbox controller
`timescale 1ns/100ps
`default_nettype none
module mbj_paper_model (
  // clock
  input  wire logic clk,
  // sensor levels, high while paper covers them
  output var  logic fuser  = 1'b0,
  output var  logic feed_a = 1'b0,
  output var  logic feed_b = 1'b0,
  output var  logic dlv    = 1'b0
);
  // one sheet: fuser edge, gap cycles to the feed sensors, len cycles over them
  task sheet(input int gap, input int len);
    fuser <= 1'b1;
    repeat (gap) @(posedge clk);
    feed_a <= 1'b1;
    feed_b <= 1'b1;
    repeat (len) @(posedge clk);
    fuser <= 1'b0;
    feed_a <= 1'b0;
    feed_b <= 1'b0;
    @(posedge clk);
  endtask
  // leave or remove a sheet on the delivery sensor
  task lay(input logic v);
    dlv <= v;
  endtask
endmodule
`default_nettype wire

//--- testbench/mbj_mailbox_ctrl_tb.sv
// self-checking bench for the mailbox controller
`timescale 1ns/100ps
`default_nettype none
`include "mbj_consts.vh"
module mbj_mailbox_ctrl_tb;
  logic        clk, rst_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, route, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        f_lo, f_mid, f_top, door, stp, full, jam, clr;
  wire         fuser, fa, fb, dlv;
  int          mismatches, total_checks, i;

  always #5 clk = ~clk;

  // controller under test
  mbj_mailbox_ctrl dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .full_low_pin(f_lo), .full_mid_pin(f_mid), .full_top_pin(f_top),
    .fuser_delivery_pin(fuser), .path_feed_sensor_a(fa), .path_feed_sensor_b(fb),
    .lowest_bin_delivery_sensor(dlv), .door_closed_pin(door), .staple_feed_start(stp),
    .route_bin(route), .full_report(full), .jam_report(jam), .clear_drive(clr));

  // paper path on the far side
  mbj_paper_model pm (.clk(clk), .fuser(fuser), .feed_a(fa), .feed_b(fb), .dlv(dlv));

  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // bus write, each channel held until its own ready
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ka, kw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(negedge clk);
      ka = awvalid && awready;
      kw = wvalid && wready;
      @(posedge clk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
      ta = ta | ka;
      tw = tw | kw;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk);
    bready <= 1'b1;  // answer left waiting one cycle
    @(negedge clk);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  // bus read
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    @(posedge clk);
    rready <= 1'b1;  // answer left waiting one cycle
    @(negedge clk);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // verdict and end of run
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog
  initial begin
    wt(20000);
    mismatches++;
    stop_test;
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    {awvalid, wvalid, bready, arvalid, rready, f_lo, f_mid, f_top, door, stp} = '0;
    mismatches = 0;
    total_checks = 0;
    wt(2);
    rst_n <= 1'b1;
    // reset values, unmapped place, short timeouts
    rd(`MBJ_OFS_CTRL, v); chk(v, 32'h0000_0000);
    rd(`MBJ_OFS_T_FEED, v); chk(v, 32'h000f_4240);
    rd(`MBJ_OFS_T_RESID, v); chk(v, 32'h003d_0900);
    rd(8'h18, v); chk(32'(r), 32'h0000_0002);
    wr(8'h18, 32'h0000_0001); chk(32'(r), 32'h0000_0002);
    for (i = 0; i < 4; i++) wr(8'(8 + 4 * i), 32'hff00_0014);
    rd(`MBJ_OFS_T_FEED, v); chk(v, 32'h0000_0014);
    $display("test 1 done");
    door <= 1'b1;
    // stacker fills from the bottom up
    for (i = 0; i < 4; i++) begin
      {f_top, f_mid, f_lo} <= 3'((1 << i) - 1);
      wt(8);
      chk(32'(route), (i > 2) ? 2 : i);
      chk(32'(full), 32'(i == 3));
    end
    {f_top, f_mid, f_lo} <= 3'b001;
    wr(`MBJ_OFS_CTRL, 32'h0000_0008);
    wt(8); chk(32'(full), 32'h0000_0001);
    // each designated bin in mailbox mode
    for (i = 0; i < 4; i++) begin
      wr(`MBJ_OFS_CTRL, 32'(1 + 2 * i));
      {f_top, f_mid, f_lo} <= 3'b000;
      wt(8); chk(32'(route), (i > 2) ? 2 : i);
      {f_top, f_mid, f_lo} <= 3'(1 << ((i > 2) ? 2 : i));
      wt(8); chk(32'(full), 32'h0000_0001);
    end
    {f_top, f_mid, f_lo} <= 3'b000;
    wr(`MBJ_OFS_CTRL, 32'h0000_0000);
    $display("test 2 done");
    // prompt sheet, late sheet, sheet that stalls on the feed sensors
    pm.sheet(5, 5); wt(8); rd(`MBJ_OFS_STATUS, v); chk(32'(v[9:4]), 0);
    pm.sheet(40, 5); wt(8); rd(`MBJ_OFS_STATUS, v); chk(32'(v[9:4]), 3);
    chk(32'(jam), 32'h0000_0001);
    pm.sheet(2, 40); wt(8); rd(`MBJ_OFS_STATUS, v); chk(32'(v[9:4]), 15);
    // staple set left on the delivery sensor
    pm.lay(1'b1);
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    wt(40); rd(`MBJ_OFS_STATUS, v); chk(32'(v[9:4]), 31);
    $display("test 3 done");
    // clearing pass removes the sheet and drops every flag
    wr(`MBJ_OFS_CTRL, 32'h0000_0010);
    wt(5); chk(32'(clr), 32'h0000_0001);
    pm.lay(1'b0);
    wt(10); chk(32'(clr), 32'h0000_0000);
    chk(32'(jam), 32'h0000_0000);
    // sheet never leaves during clearing
    pm.lay(1'b1);
    wt(8);
    wr(`MBJ_OFS_CTRL, 32'h0000_0010);
    wt(40); rd(`MBJ_OFS_STATUS, v); chk(32'(v[9:4]), 32);
    chk(32'(clr), 32'h0000_0000);
    // door close starts a check, opening aborts it
    door <= 1'b0;
    wt(8);
    door <= 1'b1;
    wt(10); chk(32'(clr), 32'h0000_0001);
    door <= 1'b0;
    wt(8); chk(32'(clr), 32'h0000_0000);
    pm.lay(1'b0);
    $display("test 4 done");
    stop_test;
  end
endmodule
`default_nettype wire
